// File: lvds_sync_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LVDS_SYNC_MAP_SVH
`define LVDS_SYNC_MAP_SVH

// Register byte offsets
`define REG_CFG_ONE        8'h00
`define REG_CFG_THREE      8'h04
`define REG_CFG_FIVE       8'h08
`define REG_CFG_SEVEN      8'h0C
`define REG_CFG_EIGHT      8'h10
`define REG_CFG_TEN        8'h14
`define REG_STATUS_ZERO    8'h18
`define REG_IRQ_STATUS     8'h1C
`define REG_IRQ_MASK       8'h20

// Field positions
`define CFG1_SYNC_FIFO_CLR 0
`define CFG3_SW_SYNC_SEL   0
`define CFG3_SW_SYNC       1
`define CFG5_SYNC_DLL_RST  0
`define CFG8_DLL_RESTART   0
`define CFG10_IFIXED_LSB   0
`define CFG10_DELAY_LSB    4
`define STAT0_DLL_LOCK     0
`define STAT0_TX_ON        1
`define STAT0_LEVEL_LSB    8
`define IRQ_SYNC           0
`define IRQ_LOCK           1
`define IRQ_UNLOCK         2
`define IRQ_OVERFLOW       3

// Reset values
`define CFG_BYTE_RST       8'h00
`define GAIN_RST           4'hF
`define IRQ_RST            4'h0

// Timing: link clock may not stand still longer than this while locked
`define CLK_PERIOD_NS      50
`define DLL_STALL_NS       1600
`define DLL_STALL_CYC      (`DLL_STALL_NS / `CLK_PERIOD_NS)
`define DLL_LOCK_EDGES     16

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// File: lvds_sync_pkg.sv
// Types shared by the input sync and delay lock block
package lvds_sync_pkg;

  // Delay lock loop progress
  typedef enum logic [1:0] {
    DLL_IDLE,
    DLL_SEEK,
    DLL_LOCKED
  } dll_state_t;

  // One captured word: sync flag on top of the 16-bit code
  typedef logic [16:0] link_word_t;

endpackage : lvds_sync_pkg

// File: ddr_capture.sv
// Double-data-rate capture of data and sync on the sampled link clock
`timescale 1ns/1ps
module ddr_capture
  import lvds_sync_pkg::*;
#(
  parameter int TAPS = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Link pins
  input  wire logic             half_rate_data_clock,
  input  wire logic [15:0]      link_data,
  input  wire logic             tx_enable_sync_line,
  // Delay setting
  input  wire logic [3:0]       dll_delay,
  // Captured words
  output logic                  word_valid,
  output link_word_t            word_data
);

  typedef struct packed {
    logic [1:0]      clk_sync;
    link_word_t      dat_first;
    link_word_t      dat_second;
    logic [TAPS-1:0] taps;
    logic            prev;
    logic            valid;
    link_word_t      word;
  } cap_state_t;

  cap_state_t st;
  cap_state_t next_st;
  logic       delayed;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: two flops on every pin, then a delay line on the clock
  always_comb begin
    next_st            = st;
    next_st.clk_sync   = {st.clk_sync[0], half_rate_data_clock};
    next_st.dat_first  = {tx_enable_sync_line, link_data};
    next_st.dat_second = st.dat_first;
    next_st.taps       = {st.taps[TAPS-2:0], st.clk_sync[1]};
    delayed            = st.taps[dll_delay];
    next_st.prev       = delayed;
    // Both clock edges carry a word, flag travels with it
    next_st.valid      = delayed ^ st.prev;
    if (delayed ^ st.prev) begin
      next_st.word = st.dat_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word_valid = st.valid;
  assign word_data  = st.word;

endmodule : ddr_capture

// File: lvds_input_sync_delay_lock.sv
// Input sync, transmit gate, FIFO and delay lock control with AXI4-Lite registers
`timescale 1ns/1ps
`include "lvds_sync_map.svh"
module lvds_input_sync_delay_lock
  import lvds_sync_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int PW    = 3
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Link pins
  input  wire logic        half_rate_data_clock,
  input  wire logic [15:0] link_data,
  input  wire logic        tx_enable_sync_line,
  // Converter side
  output logic [15:0]      primary_code,
  output logic [15:0]      complement_code,
  output logic [4:0]       full_scale_mult,
  output logic             transmit_gate,
  output logic             sync_event,
  // Delay lock controls
  output logic [2:0]       dll_ifixed,
  output logic [3:0]       dll_delay,
  output logic             dll_locked,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic                    aw_held;
    logic [7:0]              aw_addr;
    logic                    w_held;
    logic [7:0]              w_data;
    logic                    w_en;
    logic [7:0]              cfg1;
    logic [7:0]              cfg3;
    logic [7:0]              cfg5;
    logic [3:0]              gain;
    logic [7:0]              cfg10;
    logic [3:0]              irq_st;
    logic [3:0]              irq_msk;
    logic                    irq;
    dll_state_t              dll_st;
    logic [4:0]              lock_cnt;
    logic [7:0]              gap_cnt;
    logic [DEPTH-1:0][16:0]  mem;
    logic [PW:0]             wp;
    logic [PW:0]             rp;
    logic                    flag;
    logic [15:0]             sample;
    logic [15:0]             prim;
    logic [15:0]             comp;
    logic [4:0]              fs_mult;
    logic                    sync_pulse;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  logic       cap_valid;
  link_word_t cap_word;
  logic       pop;
  logic       push;
  logic       full;
  logic       eff_flag;
  logic       do_write;
  logic       wr_restart;
  logic       dll_restart;
  logic [3:0] widx;
  logic [3:0] ridx;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic [PW:0] level;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes; zero means unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      `REG_CFG_ONE:     reg_index = 4'h1;
      `REG_CFG_THREE:   reg_index = 4'h2;
      `REG_CFG_FIVE:    reg_index = 4'h3;
      `REG_CFG_SEVEN:   reg_index = 4'h4;
      `REG_CFG_EIGHT:   reg_index = 4'h5;
      `REG_CFG_TEN:     reg_index = 4'h6;
      `REG_STATUS_ZERO: reg_index = 4'h7;
      `REG_IRQ_STATUS:  reg_index = 4'h8;
      `REG_IRQ_MASK:    reg_index = 4'h9;
      default:          reg_index = 4'h0;
    endcase
  endfunction : reg_index

  ////////////////////////////////////////////////////////////////////////////
  // Link capture
  ddr_capture #(
    .TAPS (16)
  ) u_capture (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .half_rate_data_clock (half_rate_data_clock),
    .link_data            (link_data),
    .tx_enable_sync_line  (tx_enable_sync_line),
    .dll_delay            (st.cfg10[`CFG10_DELAY_LSB +: 4]),
    .word_valid           (cap_valid),
    .word_data            (cap_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st            = st;
    next_st.sync_pulse = 1'b0;
    irq_set            = 4'h0;
    irq_clr            = 4'h0;
    widx               = reg_index(st.aw_addr);
    ridx               = reg_index(araddr);
    level              = st.wp - st.rp;
    full               = (level == (PW+1)'(DEPTH));
    do_write           = st.aw_held && st.w_held && !st.bvalid;
    wr_restart         = do_write && st.w_en && (widx == 4'h5) &&
                         st.w_data[`CFG8_DLL_RESTART];

    // Write address and data taken in either order
    if (awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
      next_st.awready = 1'b0;
    end
    if (wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata[7:0];
      next_st.w_en   = wstrb[0];
      next_st.wready = 1'b0;
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = (widx == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
      if (st.w_en) begin
        case (widx)
          4'h1:    next_st.cfg1    = st.w_data;
          4'h2:    next_st.cfg3    = st.w_data;
          4'h3:    next_st.cfg5    = st.w_data;
          4'h4:    next_st.gain    = st.w_data[3:0];
          4'h6:    next_st.cfg10   = st.w_data;
          4'h8:    irq_clr         = st.w_data[3:0];
          4'h9:    next_st.irq_msk = st.w_data[3:0];
          default: next_st.cfg1    = next_st.cfg1;
        endcase
      end
    end
    if (st.bvalid && bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Read answer one cycle after the address is taken
    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = (ridx == 4'h0) ? `RESP_SLVERR : `RESP_OKAY;
      case (ridx)
        4'h1:    next_st.rdata = {24'h0, st.cfg1};
        4'h2:    next_st.rdata = {24'h0, st.cfg3};
        4'h3:    next_st.rdata = {24'h0, st.cfg5};
        4'h4:    next_st.rdata = {28'h0, st.gain};
        4'h6:    next_st.rdata = {24'h0, st.cfg10};
        4'h7: begin
          next_st.rdata = 32'h0;
          next_st.rdata[`STAT0_DLL_LOCK] = (st.dll_st == DLL_LOCKED);
          next_st.rdata[`STAT0_TX_ON]    = st.flag;
          next_st.rdata[`STAT0_LEVEL_LSB +: PW+1] = level;
        end
        4'h8:    next_st.rdata = {28'h0, st.irq_st};
        4'h9:    next_st.rdata = {28'h0, st.irq_msk};
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (st.rvalid && rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // FIFO: push each captured word in order unless full (then flag overflow), drain one per cycle
    push = cap_valid && !full;
    pop  = (st.wp != st.rp);
    if (push) begin
      next_st.mem[st.wp[PW-1:0]] = cap_word;
      next_st.wp = st.wp + 1'b1;
    end
    if (cap_valid && full) begin
      irq_set[`IRQ_OVERFLOW] = 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end

    // Gate source: software bits or the flag that rode with the word
    if (st.cfg3[`CFG3_SW_SYNC_SEL]) begin
      eff_flag = st.cfg3[`CFG3_SW_SYNC];
    end else if (pop) begin
      eff_flag = st.mem[st.rp[PW-1:0]][16];
    end else begin
      eff_flag = st.flag;
    end
    next_st.flag = eff_flag;
    if (!eff_flag) begin
      next_st.sample = 16'h0000;
    end else if (pop) begin
      next_st.sample = st.mem[st.rp[PW-1:0]][15:0];
    end

    // Rising sync flag: event, then its selected effects
    dll_restart = wr_restart;
    if (eff_flag && !st.flag) begin
      next_st.sync_pulse = 1'b1;
      irq_set[`IRQ_SYNC] = 1'b1;
      if (st.cfg1[`CFG1_SYNC_FIFO_CLR]) begin
        next_st.rp = push ? st.wp + 1'b1 : st.wp;
      end
      if (st.cfg5[`CFG5_SYNC_DLL_RST]) begin
        dll_restart = 1'b1;
      end
    end

    // Output codes: unsigned input, primary is 65535 minus code
    next_st.comp    = st.sample;
    next_st.prim    = 16'hFFFF - st.sample;
    next_st.fs_mult = {1'b0, st.gain} + 5'h01;

    // Delay lock: count steady link edges, drop lock when clock stalls
    next_st.gap_cnt = cap_valid ? 8'h00 : st.gap_cnt + 8'h01;
    case (st.dll_st)
      DLL_IDLE: begin
        next_st.gap_cnt = 8'h00;
      end
      DLL_SEEK: begin
        if (cap_valid) begin
          next_st.lock_cnt = st.lock_cnt + 5'h01;
          if (st.lock_cnt == 5'(`DLL_LOCK_EDGES - 1)) begin
            next_st.dll_st    = DLL_LOCKED;
            irq_set[`IRQ_LOCK] = 1'b1;
          end
        end else if (st.gap_cnt == 8'(`DLL_STALL_CYC)) begin
          next_st.lock_cnt = 5'h00;
        end
      end
      DLL_LOCKED: begin
        if (!cap_valid && st.gap_cnt == 8'(`DLL_STALL_CYC)) begin
          next_st.dll_st       = DLL_IDLE;
          irq_set[`IRQ_UNLOCK] = 1'b1;
        end
      end
      default: begin
        next_st.dll_st = DLL_IDLE;
      end
    endcase
    if (dll_restart) begin
      next_st.dll_st   = DLL_SEEK;
      next_st.lock_cnt = 5'h00;
      next_st.gap_cnt  = 8'h00;
    end

    // Sticky interrupt bits: a new event wins over a clear
    next_st.irq_st = (st.irq_st & ~irq_clr) | irq_set;
    next_st.irq    = |(next_st.irq_st & st.irq_msk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.cfg1    <= `CFG_BYTE_RST;
      st.cfg3    <= `CFG_BYTE_RST;
      st.cfg5    <= `CFG_BYTE_RST;
      st.gain    <= `GAIN_RST;
      st.cfg10   <= `CFG_BYTE_RST;
      st.irq_st  <= `IRQ_RST;
      st.irq_msk <= `IRQ_RST;
      st.dll_st  <= DLL_IDLE;
      st.prim    <= 16'hFFFF;
      st.fs_mult <= 5'h10;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign awready         = st.awready;
  assign wready          = st.wready;
  assign bvalid          = st.bvalid;
  assign bresp           = st.bresp;
  assign arready         = st.arready;
  assign rvalid          = st.rvalid;
  assign rresp           = st.rresp;
  assign rdata           = st.rdata;
  assign primary_code    = st.prim;
  assign complement_code = st.comp;
  assign full_scale_mult = st.fs_mult;
  assign transmit_gate   = st.flag;
  assign sync_event      = st.sync_pulse;
  assign dll_ifixed      = st.cfg10[`CFG10_IFIXED_LSB +: 3];
  assign dll_delay       = st.cfg10[`CFG10_DELAY_LSB +: 4];
  assign dll_locked      = (st.dll_st == DLL_LOCKED);
  assign irq             = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_gate_zero;
    @(posedge aclk) disable iff (!aresetn)
    !st.flag |-> st.sample == 16'h0000;
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("sample not zero while gated");

  property p_sync_event;
    @(posedge aclk) disable iff (!aresetn)
    $rose(st.flag) |-> st.sync_pulse ##1 !st.sync_pulse;
  endproperty
  a_sync_event: assert property (p_sync_event) else $error("sync event missing");

  property p_flag_aligned;
    @(posedge aclk) disable iff (!aresetn)
    (pop && !st.cfg3[`CFG3_SW_SYNC_SEL]) |=>
      st.flag == $past(st.mem[st.rp[PW-1:0]][16]);
  endproperty
  a_flag_aligned: assert property (p_flag_aligned) else $error("flag lost alignment");

  property p_sw_sync;
    @(posedge aclk) disable iff (!aresetn)
    st.cfg3[`CFG3_SW_SYNC_SEL] |=> st.flag == $past(st.cfg3[`CFG3_SW_SYNC]);
  endproperty
  a_sw_sync: assert property (p_sw_sync) else $error("software sync ignored");

  sequence s_restart_seen;
    wr_restart ##1 (st.dll_st == DLL_SEEK && st.lock_cnt == 5'h00);
  endsequence
  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    wr_restart |-> s_restart_seen;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not start seek");

  property p_lock;
    @(posedge aclk) disable iff (!aresetn)
    (st.dll_st == DLL_SEEK && cap_valid && !dll_restart &&
     st.lock_cnt == 5'(`DLL_LOCK_EDGES - 1)) |=> dll_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not reported");

  property p_gain;
    @(posedge aclk) disable iff (!aresetn)
    ##1 st.fs_mult == {1'b0, $past(st.gain)} + 5'h01;
  endproperty
  a_gain: assert property (p_gain) else $error("full scale multiple wrong");

  property p_codes;
    @(posedge aclk) disable iff (!aresetn)
    ##1 (st.comp == $past(st.sample)) && (st.prim == 16'hFFFF - $past(st.sample));
  endproperty
  a_codes: assert property (p_codes) else $error("output codes wrong");

endmodule : lvds_input_sync_delay_lock

// File: link_source.sv
// Behavioural serializer that drives the link pins of the block
`timescale 1ns/1ps
module link_source (
  // Frame control from the bench
  input  wire logic        run,
  input  wire logic        gate_level,
  input  wire logic        slow,
  input  wire logic [15:0] first_word,
  // Link pins
  output logic             half_rate_data_clock,
  output logic [15:0]      link_data,
  output logic             tx_enable_sync_line,
  // Count of words sent in this frame
  output logic [7:0]       sent
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle values before the first frame
  initial begin
    half_rate_data_clock = 1'b0;
    link_data            = 16'h0000;
    tx_enable_sync_line  = 1'b0;
    sent                 = 8'h00;
  end

  // One word per 200 ns slot (800 ns when slow), set 100 ns before one clock edge
  always begin
    #(slow ? 700 : 100);
    if (run) begin
      link_data           = first_word + 16'(sent);
      tx_enable_sync_line = gate_level;
      #100;
      half_rate_data_clock = ~half_rate_data_clock;
      sent                 = sent + 8'h01;
    end else begin
      // Clock stands still; released data toggles so no stale word survives
      link_data = ~link_data;
      sent      = 8'h00;
      #100;
    end
  end
endmodule : link_source

// File: lvds_input_sync_delay_lock_tb.sv
// Testbench for the input sync and delay lock block
`timescale 1ns/1ps
`include "lvds_sync_map.svh"
`define CHECK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module lvds_input_sync_delay_lock_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        run = 1'b0, gate_level = 1'b0, slow = 1'b0;
  logic [15:0] first_word = 16'h0000;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        half_rate_data_clock, tx_enable_sync_line, transmit_gate, sync_event, dll_locked;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] link_data, primary_code, complement_code;
  logic [4:0]  full_scale_mult;
  logic [2:0]  dll_ifixed;
  logic [3:0]  dll_delay;
  logic [7:0]  sent;
  logic [3:0]  gains [3] = '{4'h0, 4'h7, 4'hF};
  logic [7:0]  flags [2] = '{`REG_CFG_ONE, `REG_CFG_FIVE};
  int          mismatches = 0;
  int          tests_run = 0;
  int          sync_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, pulse counter and watchdog
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (sync_event === 1'b1) sync_cnt++;
  initial begin
    #(6000 * 50);
    mismatches++;
    final_report();
  end

  // Design and link source
  lvds_input_sync_delay_lock u_dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .half_rate_data_clock, .link_data, .tx_enable_sync_line, .primary_code,
    .complement_code, .full_scale_mult, .transmit_gate, .sync_event, .dll_ifixed,
    .dll_delay, .dll_locked, .irq);
  link_source u_src (.run, .gate_level, .slow, .first_word, .half_rate_data_clock,
    .link_data, .tx_enable_sync_line, .sent);

  ////////////////////////////////////////////////////////////////////////////
  // Let n edges pass, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  // Bus write; holds each channel until taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    `CHECK("bresp", bresp, er)
  endtask : axi_write

  // Bus read with expected data and response
  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    `CHECK("rresp", rresp, er)
    `CHECK("rdata", rdata, exp)
  endtask : axi_read

  // Send n words with the given gate level, then let the pipeline drain
  task automatic frame(input logic g, input logic s, input logic [15:0] w0, input int n);
    int k;
    @(posedge aclk);
    gate_level <= g;
    slow       <= s;
    first_word <= w0;
    run        <= 1'b1;
    k = 0;
    while (sent < n && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    run <= 1'b0;
    settle(12);
  endtask : frame

  // Counts and verdict
  task automatic final_report;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    `CHECK("fs_mult", full_scale_mult, 5'h10)
    `CHECK("primary", primary_code, 16'hFFFF)
    `CHECK("complement", complement_code, 16'h0000)
    `CHECK("gate", transmit_gate, 1'b0)
    `CHECK("locked", dll_locked, 1'b0)
    `CHECK("irq", irq, 1'b0)
    axi_read(`REG_CFG_SEVEN, 32'h0000000F, `RESP_OKAY);
    axi_read(`REG_CFG_TEN, 32'h0, `RESP_OKAY);
    axi_read(`REG_STATUS_ZERO, 32'h0, `RESP_OKAY);
    axi_read(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
    axi_read(8'h24, 32'h0, `RESP_SLVERR);
    axi_write(8'h24, 32'h1, `RESP_SLVERR);
    // Coarse gain boundaries
    foreach (gains[i]) begin
      axi_write(`REG_CFG_SEVEN, {28'h0, gains[i]}, `RESP_OKAY);
      axi_read(`REG_CFG_SEVEN, {28'h0, gains[i]}, `RESP_OKAY);
      `CHECK("fs_mult", full_scale_mult, {1'b0, gains[i]} + 5'h01)
    end
    // Sync effect selects
    foreach (flags[i]) begin
      axi_write(flags[i], 32'h1, `RESP_OKAY);
      axi_read(flags[i], 32'h1, `RESP_OKAY);
      axi_write(flags[i], 32'h0, `RESP_OKAY);
    end
    // Delay loop fields at full range, then the working setting
    axi_write(`REG_CFG_TEN, 32'hF7, `RESP_OKAY);
    `CHECK("ifixed", dll_ifixed, 3'h7)
    `CHECK("delay", dll_delay, 4'hF)
    axi_read(`REG_CFG_TEN, 32'hF7, `RESP_OKAY);
    axi_write(`REG_CFG_TEN, 32'h05, `RESP_OKAY);
    `CHECK("ifixed", dll_ifixed, 3'h5)
    `CHECK("delay", dll_delay, 4'h0)
    axi_write(`REG_IRQ_MASK, 32'h3, `RESP_OKAY);
    axi_read(`REG_IRQ_MASK, 32'h3, `RESP_OKAY);
    axi_write(`REG_CFG_EIGHT, 32'h1, `RESP_OKAY);
    axi_read(`REG_CFG_EIGHT, 32'h0, `RESP_OKAY);
    // Enabled frame: lock, sync pulse, aligned flag and codes
    frame(1'b1, 1'b0, 16'h1234, `DLL_LOCK_EDGES + 8);
    `CHECK("locked", dll_locked, 1'b1)
    `CHECK("gate", transmit_gate, 1'b1)
    `CHECK("complement", complement_code, 16'h1234 + 16'(`DLL_LOCK_EDGES + 7))
    `CHECK("primary", primary_code, 16'hFFFF - (16'h1234 + 16'(`DLL_LOCK_EDGES + 7)))
    `CHECK("sync_cnt", sync_cnt, 1)
    `CHECK("irq", irq, 1'b1)
    axi_read(`REG_STATUS_ZERO, 32'h3, `RESP_OKAY);
    axi_read(`REG_IRQ_STATUS, 32'h3, `RESP_OKAY);
    // Clock stands still past the stall limit
    settle(`DLL_STALL_CYC + 8);
    `CHECK("locked", dll_locked, 1'b0)
    axi_read(`REG_IRQ_STATUS, 32'h7, `RESP_OKAY);
    axi_write(`REG_IRQ_STATUS, 32'h3, `RESP_OKAY);
    settle(2);
    `CHECK("irq", irq, 1'b0)
    axi_read(`REG_IRQ_STATUS, 32'h4, `RESP_OKAY);
    axi_write(`REG_IRQ_STATUS, 32'h4, `RESP_OKAY);
    axi_read(`REG_IRQ_STATUS, 32'h0, `RESP_OKAY);
    // Gated-off frame from a slow source: zeros reach the codes
    frame(1'b0, 1'b1, 16'hABCD, 8);
    `CHECK("gate", transmit_gate, 1'b0)
    `CHECK("complement", complement_code, 16'h0000)
    `CHECK("primary", primary_code, 16'hFFFF)
    `CHECK("sync_cnt", sync_cnt, 1)
    axi_read(`REG_STATUS_ZERO, 32'h0, `RESP_OKAY);
    // Software select and sync value replace the pin
    axi_write(`REG_CFG_THREE, 32'h3, `RESP_OKAY);
    settle(2);
    `CHECK("gate", transmit_gate, 1'b1)
    `CHECK("sync_cnt", sync_cnt, 2)
    axi_write(`REG_CFG_THREE, 32'h1, `RESP_OKAY);
    settle(2);
    `CHECK("gate", transmit_gate, 1'b0)
    axi_write(`REG_CFG_THREE, 32'h0, `RESP_OKAY);
    final_report();
  end
endmodule : lvds_input_sync_delay_lock_tb
